/* design/local_bus_arbiter.sv */
`timescale 1ns/1ns
// How it works
// - Next grants from codes and present grants
// - Never grant two processors at once
// - Acquire only after master shows release code
// - Swap grants together on release, no loss
// - Processor finishes wait-stated access despite removal
// - Retry ends cycle, terminates, restarts later
// - Force retry to preempt slow secondary access, outside hold mode
// - Retried targets must tolerate retries
// - Only primary high priority breaks secondary
// - Grants settle before sampling edge
// - Request codes valid each state
// - Present grants held in clocked registers
// - Primary grant conditions
// - Secondary grant conditions
// - No grant while secondary busy, primary high
// - More secondaries at lower priority
// - Hold ranks between low and high; with no owner, high plus hold grants neither
// - Hold replaces secondary code; grant acknowledges
// - Codes: 10 low, 01 end, 11 none
// - Outputs released the state after removal
// - Hold granted when processor idle or ending
module local_bus_arbiter
    import local_bus_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset,
    local_bus_if.arbiter       link,
    input  wire logic          hold_mode,
    input  wire logic          mem_ready,
    input  wire logic          mem_fault,
    output logic               owner_primary,
    output logic               owner_secondary,
    output logic               hold_device_grant,
    output logic               no_grant_outcome,
    output logic               retry_forced
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] latched_present_grant;
        logic [1:0] grant_in_n;
        logic       local_ready;
        logic       bus_fault;
        logic [7:0] wait_count;
        logic       retry;
        logic       hold_ack;
        logic       no_grant;
        logic       release_wait;
    } arb_reg_t;

    arb_reg_t s;
    arb_reg_t next_s;

    // ------------------------------------------------------------
    // Code decode
    // ------------------------------------------------------------
    function automatic logic is_req(input logic r0);
        return ~r0;
    endfunction

    function automatic logic is_none(input logic r0, input logic r1);
        return r0 & r1;
    endfunction

    function automatic logic is_high(input logic r0, input logic r1);
        return ~r0 & ~r1;
    endfunction

    logic r0a;
    logic r1a;
    logic r0b;
    logic r1b;
    logic pa;
    logic pb;
    logic pb_held;
    logic idle;
    logic hold;
    logic ga;
    logic gb;
    logic preempt;

    assign r0a  = link.bus_request_bit_zero[SLOT_PRIMARY];
    assign r1a  = link.bus_request_bit_one[SLOT_PRIMARY];
    assign r0b  = link.bus_request_bit_zero[SLOT_SECONDARY];
    assign r1b  = link.bus_request_bit_one[SLOT_SECONDARY];
    assign pa   = s.latched_present_grant[SLOT_PRIMARY];
    assign pb   = s.latched_present_grant[SLOT_SECONDARY];
    // Cut secondary still owns the bus until it shows a release code
    assign pb_held = pb | s.release_wait;
    assign idle = ~pa & ~pb_held;
    assign hold = is_req(r0b);

    // ------------------------------------------------------------
    // Grant decision
    // ------------------------------------------------------------
    always_comb
    begin
        ga      = 1'b0;
        gb      = 1'b0;
        preempt = 1'b0;
        if (!hold_mode)
        begin
            // Primary wins ties; secondary waits for the primary's release code
            ga = (pa & is_none(r0b, r1b))
               | (pa & is_req(r0a))
               | (pb_held & r0b & is_req(r0a))
               | (idle & is_req(r0a));
            gb = (pb_held & is_none(r0a, r1a))
               | (pb_held & is_req(r0b) & r1a)
               | (pa & is_req(r0b) & r0a)
               | (idle & is_req(r0b) & ~is_req(r0a));
            preempt = pb_held & ~r0b & is_high(r0a, r1a);
        end
        else
        begin
            ga = (pa & ~hold)
               | (pa & is_high(r0a, r1a))
               | (pb_held & ~hold)
               | (idle & is_req(r0a) & ~hold);
            gb = (pb_held & hold & r1a)
               | (pa & hold & r0a)
               | (idle & hold & ~is_high(r0a, r1a));
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s                       = s;
        next_s.latched_present_grant = {gb & ~ga, ga};
        next_s.grant_in_n            = ~{gb & ~ga, ga};
        next_s.hold_ack              = hold_mode & gb & ~ga;
        next_s.no_grant              = ~ga & ~gb;
        next_s.release_wait          = pb_held & ~r0b & ~ga & ~gb;
        if (preempt)
        begin
            if (s.wait_count != RETRY_WAIT_COUNT)
            begin
                next_s.wait_count = s.wait_count + 8'h01;
            end
        end
        else
        begin
            next_s.wait_count = 8'h00;
        end
        // Retry held until the secondary shows its termination code
        next_s.retry = preempt && (next_s.wait_count == RETRY_WAIT_COUNT);
        if (next_s.retry)
        begin
            next_s.local_ready = 1'b0;
            next_s.bus_fault   = 1'b1;
        end
        else
        begin
            next_s.local_ready = mem_ready;
            next_s.bus_fault   = mem_fault;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '{latched_present_grant: GRANT_RESET, grant_in_n: GRANT_N_RESET,
                   local_ready: 1'b0, bus_fault: 1'b0, wait_count: 8'h00,
                   retry: 1'b0, hold_ack: 1'b0, no_grant: 1'b1, release_wait: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign link.bus_grant_in_n = s.grant_in_n;
    assign link.local_ready    = s.local_ready;
    assign link.bus_fault      = s.bus_fault;
    assign owner_primary       = s.latched_present_grant[SLOT_PRIMARY];
    assign owner_secondary     = s.latched_present_grant[SLOT_SECONDARY];
    assign hold_device_grant   = s.hold_ack;
    assign no_grant_outcome    = s.no_grant;
    assign retry_forced        = s.retry;

endmodule // local_bus_arbiter

/* design/local_bus_pkg.sv */
package local_bus_pkg;

    // ------------------------------------------------------------
    // Request codes, {bus_request_bit_one, bus_request_bit_zero}
    // ------------------------------------------------------------
    localparam logic [1:0] CODE_HIGH = 2'h0;
    localparam logic [1:0] CODE_TERM = 2'h1;
    localparam logic [1:0] CODE_LOW  = 2'h2;
    localparam logic [1:0] CODE_NONE = 2'h3;

    // ------------------------------------------------------------
    // Slots on the shared link
    // ------------------------------------------------------------
    localparam int SLOT_PRIMARY   = 0;
    localparam int SLOT_SECONDARY = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] GRANT_N_RESET = 2'h3;
    localparam logic [1:0] GRANT_RESET   = 2'h0;
    localparam logic [1:0] CODE_RESET    = CODE_NONE;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS     = 8;
    localparam int         RETRY_WAIT_NS     = 200;
    localparam int         RETRY_WAIT_CYCLES = (RETRY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RETRY_WAIT_COUNT  = 8'(RETRY_WAIT_CYCLES);

    // ------------------------------------------------------------
    // Processor bus-port states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        P_IDLE    = 2'h0,
        P_REQUEST = 2'h1,
        P_ACCESS  = 2'h2,
        P_TERM    = 2'h3
    } proc_state_t;

endpackage

/* design/local_bus_if.sv */
`timescale 1ns/1ns
interface local_bus_if;

    logic [1:0] bus_request_bit_zero;
    logic [1:0] bus_request_bit_one;
    logic [1:0] bus_grant_in_n;
    logic       local_ready;
    logic       bus_fault;

    modport arbiter (
        input  bus_request_bit_zero,
        input  bus_request_bit_one,
        output bus_grant_in_n,
        output local_ready,
        output bus_fault
    );

    modport processor (
        output bus_request_bit_zero,
        output bus_request_bit_one,
        input  bus_grant_in_n,
        input  local_ready,
        input  bus_fault
    );

endinterface

/* design/proc_bus_port.sv */
`timescale 1ns/1ns
module proc_bus_port
    import local_bus_pkg::*;
#(
    parameter int SLOT = SLOT_PRIMARY
)
(
    input  wire logic          clk,
    input  wire logic          reset,
    local_bus_if.processor     link,
    input  wire logic          access_valid,
    input  wire logic          access_high,
    output logic               access_accept,
    output logic               access_done,
    output logic               access_retried,
    output logic               bus_drive
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        proc_state_t state;
        logic [1:0]  code;
        logic [1:0]  req_code;
        logic        restart;
        logic        accept;
        logic        done;
        logic        retried;
        logic        drive;
    } proc_reg_t;

    proc_reg_t s;
    proc_reg_t next_s;
    logic      granted;

    assign granted = ~link.bus_grant_in_n[SLOT];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s         = s;
        next_s.accept  = 1'b0;
        next_s.done    = 1'b0;
        next_s.retried = 1'b0;
        case (s.state)
            P_IDLE:
            begin
                next_s.code = CODE_NONE;
                if (access_valid)
                begin
                    next_s.accept   = 1'b1;
                    next_s.req_code = access_high ? CODE_HIGH : CODE_LOW;
                    next_s.code     = next_s.req_code;
                    next_s.state    = P_REQUEST;
                end
            end
            P_REQUEST:
            begin
                if (granted)
                begin
                    next_s.state = P_ACCESS;
                end
            end
            P_ACCESS:
            begin
                // Access runs to its end even if the grant goes away
                if (!link.local_ready && link.bus_fault)
                begin
                    next_s.code    = CODE_TERM;
                    next_s.restart = 1'b1;
                    next_s.state   = P_TERM;
                end
                else if (link.local_ready)
                begin
                    next_s.code    = CODE_TERM;
                    next_s.restart = 1'b0;
                    next_s.state   = P_TERM;
                end
            end
            P_TERM:
            begin
                if (s.restart)
                begin
                    next_s.retried = 1'b1;
                    next_s.code    = s.req_code;
                    next_s.state   = P_REQUEST;
                end
                else if (access_valid)
                begin
                    next_s.done     = 1'b1;
                    next_s.accept   = 1'b1;
                    next_s.req_code = access_high ? CODE_HIGH : CODE_LOW;
                    next_s.code     = next_s.req_code;
                    next_s.state    = P_REQUEST;
                end
                else
                begin
                    next_s.done  = 1'b1;
                    next_s.code  = CODE_NONE;
                    next_s.state = P_IDLE;
                end
            end
            default:
            begin
                next_s.state = P_IDLE;
                next_s.code  = CODE_NONE;
            end
        endcase
        // Drive released one state after grant loss on a release code
        next_s.drive = granted || (next_s.state == P_ACCESS);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '{state: P_IDLE, code: CODE_RESET, req_code: CODE_RESET, restart: 1'b0,
                   accept: 1'b0, done: 1'b0, retried: 1'b0, drive: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign link.bus_request_bit_zero[SLOT] = s.code[0];
    assign link.bus_request_bit_one[SLOT]  = s.code[1];
    assign access_accept                   = s.accept;
    assign access_done                     = s.done;
    assign access_retried                  = s.retried;
    assign bus_drive                       = s.drive;

endmodule // proc_bus_port

/* dv/local_bus_checker_sva.sv */
`timescale 1ns/1ns
module local_bus_checker_sva
    import local_bus_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       hold_mode,
    input  wire logic [1:0] bus_request_bit_zero,
    input  wire logic [1:0] bus_request_bit_one,
    input  wire logic [1:0] bus_grant_in_n,
    input  wire logic       local_ready,
    input  wire logic       bus_fault
);
    // ------------------------------------------------------------
    // Slot codes
    // ------------------------------------------------------------
    logic [1:0] gn;
    logic [1:0] c0;
    logic [1:0] c1;
    logic       stall;
    assign gn = bus_grant_in_n;
    assign c0 = {bus_request_bit_one[0], bus_request_bit_zero[0]};
    assign c1 = {bus_request_bit_one[1], bus_request_bit_zero[1]};
    assign stall = !hold_mode && gn == 2'h3 && c0 == CODE_HIGH && c1 == CODE_LOW;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_stall_start;
        stall && !$past(stall);
    endsequence
    sequence s_released;
        (!local_ready && bus_fault) || c1 == CODE_TERM;
    endsequence
    sequence s_owner_cut;
        $past(!gn[1] && !c1[0]) && gn == 2'h3;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_grant_never_both: assert property (gn != 2'h0)
        else $error("two grants at once");
    a_reset_no_grant: assert property ($fell(reset) |-> gn == 2'h3)
        else $error("grant present after reset");
    a_primary_keeps: assert property (
        !hold_mode && !gn[0] && (c1 == CODE_NONE || !c0[0]) |=> !gn[0])
        else $error("primary lost grant");
    a_primary_acquires: assert property (
        !hold_mode && gn[0] && !c0[0] && c1[0] |=> !gn[0])
        else $error("primary not granted on release");
    a_secondary_acquires: assert property (
        !hold_mode && gn[1] && c1 == CODE_LOW && c0[0] |=> !gn[1])
        else $error("secondary not granted");
    a_secondary_low_keeps: assert property (
        !hold_mode && !gn[1] && !c1[0] && c0 == CODE_LOW |=> !gn[1])
        else $error("low request broke secondary");
    a_preempt_waits: assert property (
        !hold_mode && !gn[1] && c0 == CODE_HIGH && !c1[0] |=> gn == 2'h3)
        else $error("grant given before termination");
    a_cut_owner_waits: assert property (
        (!hold_mode && c0 == CODE_HIGH && !c1[0]) ##0 s_owner_cut |=> gn == 2'h3)
        else $error("grant given while cut owner busy");
    a_handover_swap: assert property (
        !hold_mode && !gn[0] && c0[0] && c1 == CODE_LOW |=> gn == 2'h1)
        else $error("handover not in one state");
    a_retry_bounded: assert property (s_stall_start |-> ##[0:31] s_released)
        else $error("no retry forced on stalled access");
    a_hold_acquires: assert property (
        hold_mode && !c1[0] && c0[0] |=> !gn[1])
        else $error("hold device not acknowledged");
    a_hold_below_high: assert property (
        hold_mode && !gn[0] && c0 == CODE_HIGH |=> !gn[0])
        else $error("high request lost to hold");
endmodule // local_bus_checker_sva

/* dv/tb_local_bus_grant_arbiter.sv */
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
`define WAIT_FOR(c) begin k = 0; while (!(c) && k < 300) begin @(posedge clk); #1; k++; end \
    if (!(c)) begin err_count++; $display("ERROR wait expected 1 seen 0"); end end
module tb_local_bus_grant_arbiter
    import local_bus_pkg::*;
;
    logic       clk;
    logic       reset;
    logic       hold_mode;
    logic       mem_ready;
    logic       mem_fault;
    logic [1:0] valid;
    logic [1:0] high;
    wire  [1:0] accept;
    wire  [1:0] done;
    wire  [1:0] retried;
    wire  [1:0] drive;
    logic       owner_primary;
    logic       owner_secondary;
    logic       hold_device_grant;
    logic       no_grant_outcome;
    logic       retry_forced;
    int         err_count;
    int         n_checks;
    int         k;

    // ------------------------------------------------------------
    // Both ends and checker
    // ------------------------------------------------------------
    local_bus_if bus ();
    for (genvar g = 0; g < 2; g++)
    begin : slot
        proc_bus_port #(.SLOT(g)) proc_bus_port_inst (.clk(clk), .reset(reset), .link(bus),
            .access_valid(valid[g]), .access_high(high[g]), .access_accept(accept[g]),
            .access_done(done[g]), .access_retried(retried[g]), .bus_drive(drive[g]));
    end
    local_bus_arbiter local_bus_arbiter_inst (.clk(clk), .reset(reset), .link(bus),
        .hold_mode(hold_mode), .mem_ready(mem_ready), .mem_fault(mem_fault),
        .owner_primary(owner_primary), .owner_secondary(owner_secondary),
        .hold_device_grant(hold_device_grant), .no_grant_outcome(no_grant_outcome),
        .retry_forced(retry_forced));
    local_bus_checker_sva local_bus_checker_sva_inst (.clk(clk), .reset(reset),
        .hold_mode(hold_mode), .bus_request_bit_zero(bus.bus_request_bit_zero),
        .bus_request_bit_one(bus.bus_request_bit_one), .bus_grant_in_n(bus.bus_grant_in_n),
        .local_ready(bus.local_ready), .bus_fault(bus.bus_fault));

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic req(input int s, input logic hi);
        int k;
        @(posedge clk);
        valid[s] <= 1'b1;
        high[s] <= hi;
        `WAIT_FOR(accept[s])
        `CHECK("accept", 1'b1, accept[s])
        @(posedge clk);
        valid[s] <= 1'b0;
        #1;
    endtask

    task automatic drive_mem(input logic r, input logic f);
        @(posedge clk);
        mem_ready <= r;
        mem_fault <= f;
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        #1;
        `CHECK("grants_n", 2'h3, bus.bus_grant_in_n)
        `CHECK("no grant", 1'b1, no_grant_outcome)
        `CHECK("codes", 2'h3, bus.bus_request_bit_zero & bus.bus_request_bit_one)
        `CHECK("drive", 2'h0, drive)
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        `CHECK("grants_n after", 2'h3, bus.bus_grant_in_n)
        $display("test reset done");
    endtask

    task automatic test_handover();
        req(0, 1'b0);
        `WAIT_FOR(done[0])
        `CHECK("primary owner", 1'b1, owner_primary)
        req(1, 1'b0);
        `WAIT_FOR(owner_secondary)
        `CHECK("grants_n", 2'h1, bus.bus_grant_in_n)
        `WAIT_FOR(done[1])
        fork
            req(0, 1'b0);
            req(1, 1'b0);
        join
        `CHECK("parked secondary", 1'b1, owner_secondary)
        `WAIT_FOR(owner_primary)
        `CHECK("owners", 2'h2, {owner_primary, owner_secondary})
        `WAIT_FOR(done[0])
        $display("test handover done");
    endtask

    task automatic test_preempt();
        drive_mem(1'b0, 1'b0);
        req(1, 1'b0);
        `WAIT_FOR(drive[1])
        `CHECK("drive", 1'b1, drive[1])
        req(0, 1'b1);
        `WAIT_FOR(no_grant_outcome)
        `CHECK("no grant", 1'b1, no_grant_outcome)
        `WAIT_FOR(retry_forced)
        `CHECK("retry code", 2'h1, {bus.local_ready, bus.bus_fault})
        `WAIT_FOR(retried[1])
        `CHECK("retried", 1'b1, retried[1])
        drive_mem(1'b1, 1'b0);
        `WAIT_FOR(owner_primary)
        `CHECK("primary owner", 1'b1, owner_primary)
        `WAIT_FOR(done[1])
        `CHECK("restarted", 1'b1, done[1])
        $display("test preempt done");
    endtask

    task automatic test_fault();
        drive_mem(1'b0, 1'b1);
        req(0, 1'b0);
        `WAIT_FOR(retried[0])
        `CHECK("retried", 1'b1, retried[0])
        drive_mem(1'b1, 1'b0);
        `WAIT_FOR(done[0])
        `CHECK("done", 1'b1, done[0])
        $display("test fault done");
    endtask

    task automatic test_hold();
        @(posedge clk);
        hold_mode <= 1'b1;
        drive_mem(1'b0, 1'b0);
        req(1, 1'b0);
        `WAIT_FOR(hold_device_grant)
        `CHECK("hold ack", 1'b1, hold_device_grant)
        req(0, 1'b1);
        `WAIT_FOR(no_grant_outcome)
        repeat (RETRY_WAIT_CYCLES + 5) @(posedge clk);
        #1;
        `CHECK("no retry", 2'h2, {no_grant_outcome, retry_forced})
        drive_mem(1'b1, 1'b0);
        `WAIT_FOR(owner_primary)
        `CHECK("owners", 2'h2, {owner_primary, hold_device_grant})
        `WAIT_FOR(done[0])
        $display("test hold done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("ERROR watchdog expired");
        conclude();
    end

    initial
    begin
        reset = 1'b1;
        hold_mode = 1'b0;
        mem_ready = 1'b1;
        mem_fault = 1'b0;
        valid = 2'h0;
        high = 2'h0;
        repeat (15) @(posedge clk);
        test_reset();
        test_handover();
        test_preempt();
        test_fault();
        test_hold();
        conclude();
    end
endmodule // tb_local_bus_grant_arbiter
